/* File: hw/timer_pkg.sv */
// constants for the dual unchained timer with event capture
package timer_pkg;
    // register bus
    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 32;
    localparam logic [7:0]  OFF_GLOBAL_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_CONTROL_WORD  = 8'h04;
    localparam logic [7:0]  OFF_LOWER_COUNT   = 8'h08;
    localparam logic [7:0]  OFF_UPPER_COUNT   = 8'h0C;
    localparam logic [7:0]  OFF_LOWER_PERIOD  = 8'h10;
    localparam logic [7:0]  OFF_UPPER_PERIOD  = 8'h14;
    localparam logic [7:0]  OFF_LOWER_RELOAD  = 8'h18;
    localparam logic [7:0]  OFF_UPPER_RELOAD  = 8'h1C;
    localparam logic [7:0]  OFF_LOWER_CAPTURE = 8'h20;
    localparam logic [7:0]  OFF_UPPER_CAPTURE = 8'h24;

    // global_timer_control fields
    localparam int          GTC_RUN_LSB       = 0;
    localparam int          GTC_MODE_LSB      = 2;
    localparam int          GTC_LEGACY_BIT    = 4;
    localparam int          GTC_PSC_PER_LSB   = 8;
    localparam int          GTC_PSC_CNT_LSB   = 12;
    localparam logic [31:0] GTC_STORE_MASK    = 32'h00000F1F;
    localparam logic [31:0] GTC_RESET         = 32'h00000000;

    // timer_control_word fields, per half at a stride of 16
    localparam int          TCW_HALF_STRIDE   = 16;
    localparam int          TCW_ENA_LSB       = 6;
    localparam int          TCW_CLOCK_SOURCE_SEL_BIT    = 8;
    localparam int          TCW_CAPEN_BIT     = 11;
    localparam int          TCW_CAPEDGE_LSB   = 12;
    localparam logic [31:0] TCW_STORE_MASK    = 32'h39C039C0;
    localparam logic [31:0] TCW_RESET         = 32'h00000000;

    localparam logic [31:0] COUNT_RESET       = 32'h00000000;
    localparam logic [31:0] PERIOD_RESET      = 32'h00000000;
    localparam logic [3:0]  PSC_RESET         = 4'h0;

    // timer_mode_select values
    localparam logic [1:0]  MODE_UNCHAINED    = 2'h1;

    // half_enable_mode values
    localparam logic [1:0]  ENA_OFF           = 2'h0;
    localparam logic [1:0]  ENA_ONESHOT       = 2'h1;
    localparam logic [1:0]  ENA_CONT          = 2'h2;
    localparam logic [1:0]  ENA_RELOAD        = 2'h3;

    // capture edge selection values; anything else means both edges
    localparam logic [1:0]  EDGE_RISE         = 2'h0;
    localparam logic [1:0]  EDGE_FALL         = 2'h1;
endpackage : timer_pkg

/* File: hw/dual_unchained_timer_capture.sv */
// dual 32-bit unchained timer with 4-bit prescaler and event capture
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// RL1: mode field value 1 selects dual unchained
// RL2: upper half prescaled, lower half counts directly
// RL3: upper prescaler clock internal or external
// RL4: prescaler counts, pulses cycle after period match
// RL5: upper counter steps per pulse, events on match
// RL6: lower counter steps per clock, events on match
// RL7: continuous modes clear counter cycle after match
// RL8: per-half run bit, zero holds half reset
// RL9: enable mode 0 freezes the counter
// RL10: enable mode 1 counts to period, stops
// RL11: enable mode 2 wraps to zero, repeats
// RL12: enable mode 3 reloads period at wrap
// RL13: external clock synchronised; software waits one period
// RL14: zero counter and period never advance
// RL15: software writes reload before cycle ends
// RL16: software setup order for unchained half
// RL17: software setup order for chained operation
// RL18: each half ignores other half's control bits
// RL19: capture only on capable instance, legacy, unchained
// RL20: capture event: events, copy, reload, restart
// RL21: capture needs internal clock, continuous mode
// RL22: per-half capture enable and edge select
// RL23: outside unchained mode upper enable does nothing
// RL24: capture input synchronised, one action per edge
module dual_unchained_timer_capture
    import timer_pkg::*;
#(
    parameter bit CAPTURE_SUPPORTED = 1'b1
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              we_i,
    input  wire logic              re_i,
    output logic      [DATA_W-1:0] rdata_o,
    // pins
    input  wire logic              ext_clk_i,
    input  wire logic              lower_capture_i,
    input  wire logic              upper_capture_i,
    // lower half events
    output logic                   lower_timer_irq_o,
    output logic                   lower_timer_dma_event_o,
    output logic                   lower_real_time_output_o,
    // upper half events
    output logic                   upper_timer_irq_o,
    output logic                   upper_timer_dma_event_o,
    output logic                   upper_real_time_output_o
);

    // register file state
    logic [31:0] gtc_reg;
    logic [31:0] gtc_next;
    logic [31:0] ctl_reg;
    logic [31:0] ctl_next;
    logic [31:0] rel_reg  [2];
    logic [31:0] rel_next [2];
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // per-half counting state, index 0 lower, 1 upper
    logic [31:0] cnt_reg  [2];
    logic [31:0] cnt_next [2];
    logic [31:0] prd_reg  [2];
    logic [31:0] prd_next [2];
    logic [31:0] cap_reg  [2];
    logic [31:0] cap_next [2];
    logic [1:0]  evt_reg;
    logic [1:0]  evt_next;
    logic [3:0]  psc_reg;
    logic [3:0]  psc_next;
    logic        psc_pulse_reg;
    logic        psc_pulse_next;

    // synchronisers: stage one is read only by stage two
    logic        ext_s1_reg;
    logic        ext_s2_reg;
    logic        ext_s3_reg;
    logic [1:0]  cap_s1_reg;
    logic [1:0]  cap_s2_reg;
    logic [1:0]  cap_s3_reg;

    // decoded control
    logic        unchained;
    logic        legacy;
    logic        ext_rise;
    logic [1:0]  run;
    logic [1:0]  active;
    logic [1:0]  in_tick;
    logic [1:0]  count_tick;
    logic [1:0]  cap_hit;
    logic [1:0]  cnt_we;
    logic [1:0]  prd_we;
    logic [1:0]  rel_we;
    logic [1:0]  mode [2];
    logic        psc_we;
    logic [3:0]  psc_period;

    assign unchained  = gtc_reg[GTC_MODE_LSB +: 2] == MODE_UNCHAINED; // [RL1]
    assign legacy     = gtc_reg[GTC_LEGACY_BIT];
    assign psc_period = gtc_reg[GTC_PSC_PER_LSB +: 4];
    assign ext_rise   = ext_s2_reg & ~ext_s3_reg; // [RL13]
    assign psc_we     = we_i && (addr_i == OFF_GLOBAL_CTRL);
    assign cnt_we[0]  = we_i && (addr_i == OFF_LOWER_COUNT);
    assign cnt_we[1]  = we_i && (addr_i == OFF_UPPER_COUNT);
    assign prd_we[0]  = we_i && (addr_i == OFF_LOWER_PERIOD);
    assign prd_we[1]  = we_i && (addr_i == OFF_UPPER_PERIOD);
    assign rel_we[0]  = we_i && (addr_i == OFF_LOWER_RELOAD);
    assign rel_we[1]  = we_i && (addr_i == OFF_UPPER_RELOAD);

    // the upper half sees only prescaler pulses, the lower half raw ticks
    assign count_tick[0] = in_tick[0]; // [RL2] [RL6]
    assign count_tick[1] = psc_pulse_reg; // [RL2] [RL5]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
            cap_s1_reg <= 2'h0;
            cap_s2_reg <= 2'h0;
            cap_s3_reg <= 2'h0;
        end else begin
            ext_s1_reg <= ext_clk_i;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            cap_s1_reg <= {upper_capture_i, lower_capture_i}; // [RL24]
            cap_s2_reg <= cap_s1_reg;
            cap_s3_reg <= cap_s2_reg;
        end
    end

    // register writes and read data, answered one cycle later
    always_comb begin
        gtc_next    = gtc_reg;
        ctl_next    = ctl_reg;
        rel_next[0] = rel_reg[0];
        rel_next[1] = rel_reg[1];
        rdata_next  = 32'h00000000;
        if (psc_we) begin
            gtc_next = wdata_i & GTC_STORE_MASK;
        end
        if (we_i && (addr_i == OFF_CONTROL_WORD)) begin
            ctl_next = wdata_i & TCW_STORE_MASK;
        end
        // reload stays writable while running, so software can stage it
        if (rel_we[0]) begin
            rel_next[0] = wdata_i; // [RL15]
        end
        if (rel_we[1]) begin
            rel_next[1] = wdata_i; // [RL15]
        end
        if (re_i) begin
            case (addr_i)
                OFF_GLOBAL_CTRL: begin
                    rdata_next = gtc_reg;
                    rdata_next[GTC_PSC_CNT_LSB +: 4] = psc_reg;
                end
                OFF_CONTROL_WORD:  rdata_next = ctl_reg;
                OFF_LOWER_COUNT:   rdata_next = cnt_reg[0];
                OFF_UPPER_COUNT:   rdata_next = cnt_reg[1];
                OFF_LOWER_PERIOD:  rdata_next = prd_reg[0];
                OFF_UPPER_PERIOD:  rdata_next = prd_reg[1];
                OFF_LOWER_RELOAD:  rdata_next = rel_reg[0];
                OFF_UPPER_RELOAD:  rdata_next = rel_reg[1];
                OFF_LOWER_CAPTURE: rdata_next = cap_reg[0];
                OFF_UPPER_CAPTURE: rdata_next = cap_reg[1];
                default:           rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gtc_reg    <= GTC_RESET;
            ctl_reg    <= TCW_RESET;
            rel_reg[0] <= PERIOD_RESET;
            rel_reg[1] <= PERIOD_RESET;
            rdata_reg  <= 32'h00000000;
        end else begin
            gtc_reg    <= gtc_next;
            ctl_reg    <= ctl_next;
            rel_reg[0] <= rel_next[0];
            rel_reg[1] <= rel_next[1];
            rdata_reg  <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;

    // 4-bit prescaler for the upper half
    always_comb begin
        psc_next       = psc_reg;
        psc_pulse_next = 1'b0;
        if (!run[1]) begin
            psc_next = PSC_RESET; // [RL8]
        end else if (psc_we) begin
            psc_next = wdata_i[GTC_PSC_CNT_LSB +: 4];
        end else if (active[1] && in_tick[1]) begin
            if (psc_reg == psc_period) begin
                psc_next       = PSC_RESET;
                psc_pulse_next = 1'b1; // [RL4]
            end else begin
                psc_next = psc_reg + 4'h1; // [RL4]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            psc_reg       <= PSC_RESET;
            psc_pulse_reg <= 1'b0;
        end else begin
            psc_reg       <= psc_next;
            psc_pulse_reg <= psc_pulse_next;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_prescale_pulse: assert property (
        active[1] && in_tick[1] && run[1] && !psc_we &&
        psc_reg == psc_period |=> psc_pulse_reg && psc_reg == 4'h0) // [RL4]
        else $error("prescaler pulse missing after period match");

    a_upper_only_pulse: assert property (
        active[1] && !cap_hit[1] && !cnt_we[1] && !psc_pulse_reg &&
        !(cnt_reg[1] == prd_reg[1] && mode[1] == ENA_ONESHOT)
        |=> cnt_reg[1] == $past(cnt_reg[1])) // [RL2]
        else $error("upper counter moved without prescaler pulse");

    c_prescale_pulse: cover property (
        psc_pulse_reg ##1 !psc_pulse_reg);

    for (genvar h = 0; h < 2; h++) begin : g_half
        localparam int B = h * TCW_HALF_STRIDE;
        logic       srcsel;
        logic       capen;
        logic [1:0] edgesel;
        logic       cap_rise;
        logic       cap_fall;
        logic       cap_ok;

        // each half reads only its own 16 control bits
        assign mode[h]  = ctl_reg[B + TCW_ENA_LSB +: 2]; // [RL18]
        assign srcsel   = ctl_reg[B + TCW_CLOCK_SOURCE_SEL_BIT];
        assign capen    = ctl_reg[B + TCW_CAPEN_BIT]; // [RL22]
        assign edgesel  = ctl_reg[B + TCW_CAPEDGE_LSB +: 2]; // [RL22]
        assign run[h]   = gtc_reg[GTC_RUN_LSB + h]; // [RL8]
        assign in_tick[h] = srcsel ? ext_rise : 1'b1; // [RL3] [RL13]
        // outside unchained mode neither enable field runs a half
        assign active[h] = run[h] && unchained && mode[h] != ENA_OFF; // [RL23]
        assign cap_rise = cap_s2_reg[h] & ~cap_s3_reg[h]; // [RL24]
        assign cap_fall = ~cap_s2_reg[h] & cap_s3_reg[h]; // [RL24]
        assign cap_ok   = CAPTURE_SUPPORTED && legacy && unchained &&
                          run[h] && capen && !srcsel && mode[h][1]; // [RL19] [RL21]
        always_comb begin
            case (edgesel)
                EDGE_RISE: cap_hit[h] = cap_ok && cap_rise; // [RL22]
                EDGE_FALL: cap_hit[h] = cap_ok && cap_fall; // [RL22]
                default:   cap_hit[h] = cap_ok && (cap_rise || cap_fall);
            endcase
        end

        always_comb begin
            cnt_next[h] = cnt_reg[h];
            prd_next[h] = prd_reg[h];
            cap_next[h] = cap_reg[h];
            evt_next[h] = 1'b0;
            if (prd_we[h]) begin
                prd_next[h] = wdata_i;
            end
            if (!run[h]) begin
                cnt_next[h] = COUNT_RESET; // [RL8]
            end else if (cnt_we[h]) begin
                cnt_next[h] = wdata_i;
            end else if (cap_hit[h]) begin
                // restart the cycle: snapshot, events, reload in reload mode, count from 0
                cap_next[h] = cnt_reg[h]; // [RL20]
                evt_next[h] = 1'b1; // [RL20]
                cnt_next[h] = COUNT_RESET; // [RL20]
                if (mode[h] == ENA_RELOAD) begin
                    prd_next[h] = rel_reg[h]; // [RL20]
                end
            end else if (active[h] && count_tick[h]) begin
                if (cnt_reg[h] == prd_reg[h]) begin
                    // one-shot simply holds here; equal zeros never move
                    if (mode[h] != ENA_ONESHOT) begin // [RL10] [RL14]
                        cnt_next[h] = COUNT_RESET; // [RL7] [RL11]
                        if (mode[h] == ENA_RELOAD) begin
                            prd_next[h] = rel_reg[h]; // [RL12]
                        end
                    end
                end else begin
                    // counts past all-ones roll over to zero naturally
                    cnt_next[h] = cnt_reg[h] + 32'h00000001; // [RL5] [RL6]
                    if (cnt_reg[h] + 32'h00000001 == prd_reg[h]) begin
                        evt_next[h] = 1'b1; // [RL5] [RL6]
                    end
                end
            end
            // mode 0 leaves every value untouched [RL9]
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cnt_reg[h] <= COUNT_RESET;
                prd_reg[h] <= PERIOD_RESET;
                cap_reg[h] <= COUNT_RESET;
                evt_reg[h] <= 1'b0;
            end else begin
                cnt_reg[h] <= cnt_next[h];
                prd_reg[h] <= prd_next[h];
                cap_reg[h] <= cap_next[h];
                evt_reg[h] <= evt_next[h];
            end
        end

        a_reset_hold: assert property (
            !run[h] |=> cnt_reg[h] == 32'h00000000) // [RL8]
            else $error("half counter not held at zero in reset");

        a_disabled_hold: assert property (
            run[h] && mode[h] == ENA_OFF && !cnt_we[h] && !cap_hit[h]
            |=> cnt_reg[h] == $past(cnt_reg[h])) // [RL9]
            else $error("disabled half changed its counter");

        a_count_step: assert property (
            active[h] && count_tick[h] && !cnt_we[h] && !cap_hit[h] &&
            cnt_reg[h] != prd_reg[h]
            |=> cnt_reg[h] == $past(cnt_reg[h]) + 32'h00000001) // [RL6]
            else $error("counter did not advance by one");

        a_match_event: assert property (
            active[h] && count_tick[h] && !cnt_we[h] && !cap_hit[h] &&
            cnt_reg[h] != prd_reg[h] &&
            cnt_reg[h] + 32'h00000001 == prd_reg[h]
            |=> evt_reg[h] ##1 !evt_reg[h] || cap_hit[h]) // [RL5]
            else $error("match did not raise a one-cycle event");

        a_wrap_clear: assert property (
            active[h] && mode[h][1] && count_tick[h] && !cnt_we[h] &&
            !cap_hit[h] && cnt_reg[h] == prd_reg[h]
            |=> cnt_reg[h] == 32'h00000000) // [RL7]
            else $error("continuous counter not cleared after match");

        a_oneshot_stop: assert property (
            active[h] && mode[h] == ENA_ONESHOT && !cnt_we[h] &&
            cnt_reg[h] == prd_reg[h] |=> $stable(cnt_reg[h])) // [RL10]
            else $error("one-shot counter ran past its period");

        a_reload_copy: assert property (
            active[h] && mode[h] == ENA_RELOAD && count_tick[h] &&
            !cnt_we[h] && !cap_hit[h] && !prd_we[h] &&
            cnt_reg[h] == prd_reg[h] |=> prd_reg[h] == $past(rel_reg[h])) // [RL12]
            else $error("period not reloaded at wrap");

        a_capture_copy: assert property (
            cap_hit[h] && !cnt_we[h] |=> cap_reg[h] == $past(cnt_reg[h]) &&
            cnt_reg[h] == 32'h00000000 && evt_reg[h]) // [RL20]
            else $error("capture did not snapshot and restart");

        a_capture_gate: assert property (
            cap_hit[h] |-> CAPTURE_SUPPORTED && legacy && unchained &&
            !srcsel && mode[h][1]) // [RL19] [RL21]
            else $error("capture taken while not permitted");

        c_wrap: cover property (
            active[h] && mode[h] == ENA_CONT && evt_reg[h] ##[1:40]
            cnt_reg[h] == 32'h00000000);
        c_capture: cover property (cap_hit[h] ##1 evt_reg[h]);
        c_reload: cover property (
            mode[h] == ENA_RELOAD && $changed(prd_reg[h]) && !$past(prd_we[h]));
    end

    a_read_latency: assert property (
        re_i && addr_i == OFF_LOWER_PERIOD |=> rdata_o == $past(prd_reg[0]))
        else $error("read data not presented one cycle after strobe");

    assign lower_timer_irq_o        = evt_reg[0];
    assign lower_timer_dma_event_o  = evt_reg[0];
    assign lower_real_time_output_o = evt_reg[0];
    assign upper_timer_irq_o        = evt_reg[1];
    assign upper_timer_dma_event_o  = evt_reg[1];
    assign upper_real_time_output_o = evt_reg[1];

endmodule : dual_unchained_timer_capture

/* File: sim/tb.sv */
// self-checking bench for the dual unchained timer with capture
`timescale 1ns/1ps
module tb;
    import timer_pkg::*;
    // design ports
    logic              clk_i;
    logic              rst_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i;
    logic              we_i;
    logic              re_i;
    logic [DATA_W-1:0] rdata_o;
    logic              ext_clk_i;
    logic              lower_capture_i;
    logic              upper_capture_i;
    logic [2:0]        lower_ev;
    logic [2:0]        upper_ev;
    // bookkeeping
    int                mismatches = 0;
    int                checks_done = 0;
    int                lower_events = 0;
    int                upper_events = 0;
    logic [31:0]       v;
    logic [31:0]       w;

    dual_unchained_timer_capture dut_u (
        .clk_i                    (clk_i),
        .rst_i                    (rst_i),
        .addr_i                   (addr_i),
        .wdata_i                  (wdata_i),
        .we_i                     (we_i),
        .re_i                     (re_i),
        .rdata_o                  (rdata_o),
        .ext_clk_i                (ext_clk_i),
        .lower_capture_i          (lower_capture_i),
        .upper_capture_i          (upper_capture_i),
        .lower_timer_irq_o        (lower_ev[2]),
        .lower_timer_dma_event_o  (lower_ev[1]),
        .lower_real_time_output_o (lower_ev[0]),
        .upper_timer_irq_o        (upper_ev[2]),
        .upper_timer_dma_event_o  (upper_ev[1]),
        .upper_real_time_output_o (upper_ev[0])
    );

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    // the three event ports must pulse together; looked at mid-cycle
    always @(negedge clk_i) begin
        if (lower_ev != 3'h0) begin
            chk({29'h0, lower_ev}, 32'h00000007);
            lower_events++;
        end
        if (upper_ev != 3'h0) begin
            chk({29'h0, upper_ev}, 32'h00000007);
            upper_events++;
        end
    end

    // gap cycle after each strobe keeps drivers to one update per step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i  <= a;
        wdata_i <= d;
        we_i    <= 1'b1;
        @(posedge clk_i);
        we_i    <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr_i <= a;
        re_i   <= 1'b1;
        @(posedge clk_i);
        re_i   <= 1'b0;
        #1 d = rdata_o;
        @(posedge clk_i);
    endtask : rd

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask : expect_reg

    // counting edges from enable to disable come to n + 2
    task automatic run_tcw(input logic [31:0] tcw, input int n);
        wr(OFF_CONTROL_WORD, tcw);
        repeat (n) @(posedge clk_i);
        wr(OFF_CONTROL_WORD, 32'h00000000);
    endtask : run_tcw

    task automatic t_registers();
        logic [7:0] a;
        for (a = 8'h00; a <= 8'h24; a += 8'h04) begin
            expect_reg(a, 32'h00000000);
        end
        expect_reg(8'h40, 32'h00000000);
        wr(OFF_CONTROL_WORD, 32'hFFFFFFFF);
        expect_reg(OFF_CONTROL_WORD, TCW_STORE_MASK);
        wr(OFF_CONTROL_WORD, 32'h00000000);
    endtask : t_registers

    task automatic t_lower_wrap();
        int e0;
        e0 = lower_events;
        wr(OFF_GLOBAL_CTRL, 32'h00000005);
        wr(OFF_LOWER_PERIOD, 32'h00000004);
        run_tcw(32'h00000080, 9);
        expect_reg(OFF_LOWER_COUNT, 32'h00000001);
        chk(32'(lower_events - e0), 32'h00000002);
        repeat (5) @(posedge clk_i);
        expect_reg(OFF_LOWER_COUNT, 32'h00000001);
    endtask : t_lower_wrap

    task automatic t_oneshot();
        int e0;
        e0 = lower_events;
        wr(OFF_LOWER_COUNT, 32'h00000000);
        wr(OFF_LOWER_PERIOD, 32'h00000003);
        run_tcw(32'h00000040, 9);
        expect_reg(OFF_LOWER_COUNT, 32'h00000003);
        chk(32'(lower_events - e0), 32'h00000001);
    endtask : t_oneshot

    task automatic t_reload();
        wr(OFF_LOWER_COUNT, 32'h00000000);
        wr(OFF_LOWER_PERIOD, 32'h00000002);
        wr(OFF_LOWER_RELOAD, 32'h00000005);
        run_tcw(32'h000000C0, 6);
        expect_reg(OFF_LOWER_COUNT, 32'h00000005);
        expect_reg(OFF_LOWER_PERIOD, 32'h00000005);
    endtask : t_reload

    // run bit low, three foreign modes, zero period
    task automatic t_hold();
        logic [31:0] g [5] = '{32'h00000004, 32'h00000001,
                               32'h00000009, 32'h00000005,
                               32'h0000000F};
        logic [31:0] p [5] = '{32'h00000004, 32'h00000004,
                               32'h00000004, 32'h00000000,
                               32'h00000004};
        int          e0;
        e0 = lower_events;
        for (int i = 0; i < 5; i++) begin
            wr(OFF_GLOBAL_CTRL, g[i]);
            wr(OFF_LOWER_COUNT, 32'h00000000);
            wr(OFF_LOWER_PERIOD, p[i]);
            run_tcw(32'h00000080, 5);
            expect_reg(OFF_LOWER_COUNT, 32'h00000000);
        end
        chk(32'(lower_events - e0), 32'h00000000);
        expect_reg(OFF_UPPER_COUNT, 32'h00000000);
    endtask : t_hold

    // prescale period 2: one upper step per three clocks
    task automatic t_prescale();
        int e0;
        e0 = upper_events;
        wr(OFF_GLOBAL_CTRL, 32'h00000207);
        wr(OFF_UPPER_PERIOD, 32'h00000002);
        run_tcw(32'h00800000, 12);
        expect_reg(OFF_UPPER_COUNT, 32'h00000001);
        chk(32'(upper_events - e0), 32'h00000001);
        rd(OFF_GLOBAL_CTRL, v);
        chk({28'h0, v[15:12]}, 32'h00000002);
        expect_reg(OFF_LOWER_COUNT, 32'h00000000);
    endtask : t_prescale

    task automatic t_ext();
        wr(OFF_GLOBAL_CTRL, 32'h00000007);
        wr(OFF_UPPER_PERIOD, 32'h00000064);
        wr(OFF_UPPER_COUNT, 32'h00000000);
        wr(OFF_CONTROL_WORD, 32'h01800000);
        repeat (5) begin
            ext_clk_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            ext_clk_i <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        wr(OFF_CONTROL_WORD, 32'h00000000);
        expect_reg(OFF_UPPER_COUNT, 32'h00000005);
    endtask : t_ext

    // columns: global control, control word, events, capture + count
    task automatic t_capture();
        logic [31:0] t [8][4] = '{
            '{32'h17, 32'h00000880, 32'h1, 32'hD},
            '{32'h17, 32'h00001880, 32'h1, 32'hD},
            '{32'h17, 32'h000028C0, 32'h2, 32'hFFFFFFFF},
            '{32'h17, 32'h00000980, 32'h0, 32'hFFFFFFFF},
            '{32'h17, 32'h00000840, 32'h0, 32'hFFFFFFFF},
            '{32'h17, 32'h00000080, 32'h0, 32'hFFFFFFFF},
            '{32'h07, 32'h00000880, 32'h0, 32'hFFFFFFFF},
            '{32'h17, 32'h08800000, 32'h1, 32'hFFFFFFFF}};
        int          e0;
        wr(OFF_LOWER_PERIOD, 32'h000003E8);
        wr(OFF_LOWER_RELOAD, 32'h000003E8);
        for (int i = 0; i < 8; i++) begin
            e0 = lower_events + upper_events;
            wr(OFF_GLOBAL_CTRL, t[i][0]);
            wr(OFF_LOWER_COUNT, 32'h00000000);
            wr(OFF_UPPER_COUNT, 32'h00000000);
            wr(OFF_CONTROL_WORD, t[i][1]);
            lower_capture_i <= 1'b1;
            upper_capture_i <= 1'b1;
            repeat (6) @(posedge clk_i);
            lower_capture_i <= 1'b0;
            upper_capture_i <= 1'b0;
            repeat (6) @(posedge clk_i);
            wr(OFF_CONTROL_WORD, 32'h00000000);
            chk(32'(lower_events + upper_events - e0), t[i][2]);
            if (t[i][3] != 32'hFFFFFFFF) begin
                rd(OFF_LOWER_CAPTURE, v);
                rd(OFF_LOWER_COUNT, w);
                chk(v + w, t[i][3]);
            end
        end
        rd(OFF_LOWER_CAPTURE, v);
        wr(OFF_LOWER_CAPTURE, 32'hFFFFFFFF);
        expect_reg(OFF_LOWER_CAPTURE, v);
    endtask : t_capture

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (4000) @(posedge clk_i);
        mismatches++;
        report_and_stop();
    end

    initial begin
        rst_i           = 1'b1;
        addr_i          = 8'h00;
        wdata_i         = 32'h00000000;
        we_i            = 1'b0;
        re_i            = 1'b0;
        ext_clk_i       = 1'b0;
        lower_capture_i = 1'b0;
        upper_capture_i = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_registers();
        t_lower_wrap();
        t_oneshot();
        t_reload();
        t_hold();
        t_prescale();
        t_ext();
        t_capture();
        report_and_stop();
    end
endmodule : tb
